// *** hw/sensor_test_config_regs.sv ***
// Sensor register bank: serial port slave, self-test, settings, observation and burst read
`timescale 1ns/100ps
`default_nettype none

module sensor_test_config_regs #(
  parameter int DIAG_CYCLES = sensor_test_config_pkg::DIAG_RUN_CYCLES,
  parameter logic [7:0] SILICON_VERSION_CODE = 8'h5c, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3b // arbitrary value
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic frame_done,
  input wire sensor_test_config_pkg::frame_report_type frame_info,
  input wire sensor_test_config_pkg::power_mode_type power_mode,
  input wire logic diag_pass,
  output logic diag_running,
  output logic tracking_enable,
  output logic soft_reset_pulse,
  output logic cpi_select,
  output logic [1:0] forced_sleep_select
);

  // ---------------- Link side (serial clock) ----------------
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] addr_q;
  logic addr_done_q;
  logic [2:0] data_byte_q;
  logic [7:0] out_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic clr_tgl_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [6:0] rd_addr_q;
  logic byte_end;
  logic [7:0] full_byte;
  logic link_reading;

  // ---------------- Core side ----------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic wr_fire;
  logic rd_fire;
  logic clr_fire;
  logic soft_rst_q;
  logic [7:0] settings_q;
  logic [3:0] frame_alive_bits_q;
  logic [7:0] delta_y_q;
  logic [7:0] delta_x_q;
  logic movement_flag;
  logic diag_busy_q;
  logic diag_done_q;
  logic [31:0] diag_cnt_q;
  logic [31:0] diag_result_q;
  logic [7:0] read_byte;
  sensor_test_config_pkg::burst_bundle_type burst_now;
  sensor_test_config_pkg::burst_bundle_type bundle_q;
  logic [7:0] bundle_byte;
  logic clear_dy;
  logic clear_dx;
  logic core_wr_ok;

  // Saturating signed add for motion accumulation
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7]) begin
      sat_add = s[8] ? 8'h80 : 8'h7f;
    end else begin
      sat_add = s[7:0];
    end
  endfunction

  // Byte framing helpers
  assign byte_end = (bit_cnt_q == 3'h7);
  assign full_byte = {shift_q, mosi};
  assign link_reading = addr_done_q && !addr_q[sensor_test_config_pkg::ADDR_WRITE_BIT];

  // Bit and byte framing, cleared by deselect
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      addr_q <= 8'h00;
      addr_done_q <= 1'b0;
      data_byte_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= full_byte[6:0];
      if (byte_end && !addr_done_q) begin
        addr_q <= full_byte;
        addr_done_q <= 1'b1;
      end else if (byte_end && data_byte_q != 3'h7) begin
        data_byte_q <= data_byte_q + 3'h1;
      end
    end
  end

  // Events and their held words toward the core
  always_ff @(posedge link_sclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      clr_tgl_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
      rd_addr_q <= 7'h00;
    end else if (!cs_n && byte_end) begin
      if (!addr_done_q && !full_byte[sensor_test_config_pkg::ADDR_WRITE_BIT]) begin
        rd_addr_q <= full_byte[6:0];
        rd_tgl_q <= !rd_tgl_q;
      end else if (addr_done_q && addr_q[sensor_test_config_pkg::ADDR_WRITE_BIT]
                   && data_byte_q == 3'h0) begin
        wr_addr_q <= addr_q[6:0];
        wr_data_q <= full_byte;
        wr_tgl_q <= !wr_tgl_q;
      end else if (link_reading
                   && addr_q[6:0] == sensor_test_config_pkg::MOVEMENT_BURST_PORT_OFS
                   && data_byte_q == sensor_test_config_pkg::BURST_CLEAR_BYTES - 3'h1) begin
        clr_tgl_q <= !clr_tgl_q;
      end
    end
  end

  // Pick the byte for the current data slot; bundle is held still across the slot
  always_comb begin
    bundle_byte = 8'h00;
    if (data_byte_q < 3'(sensor_test_config_pkg::BURST_BYTES)) begin
      bundle_byte = bundle_q[8 * (6 - int'(data_byte_q)) +: 8];
    end
  end

  // Output shifter, changes on the falling edge
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      out_q <= 8'h00;
    end else if (link_reading && bit_cnt_q == 3'h0) begin
      out_q <= bundle_byte;
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign miso = out_q[7];
  assign miso_oe = !cs_n && link_reading;

  // Two-flop synchronisers plus edge stage for the three link events
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {clr_tgl_q, rd_tgl_q, wr_tgl_q};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign wr_fire = sync2_q[0] ^ sync3_q[0];
  assign rd_fire = sync2_q[1] ^ sync3_q[1];
  assign clr_fire = sync2_q[2] ^ sync3_q[2];
  assign core_wr_ok = wr_fire && !diag_busy_q;

  // Keyed soft reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= core_wr_ok && wr_addr_q == sensor_test_config_pkg::SOFT_RESET_KEY_OFS
                    && wr_data_q == sensor_test_config_pkg::SOFT_RESET_KEY;
    end
  end

  assign soft_reset_pulse = soft_rst_q;

  // Sensor settings register
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_rst_q) begin
      settings_q <= sensor_test_config_pkg::SENSOR_SETTINGS_RESET;
    end else if (core_wr_ok && wr_addr_q == sensor_test_config_pkg::SENSOR_SETTINGS_OFS) begin
      settings_q <= (wr_data_q & ~sensor_test_config_pkg::SETTINGS_RESERVED_MASK)
                    | (sensor_test_config_pkg::SENSOR_SETTINGS_RESET
                       & sensor_test_config_pkg::SETTINGS_RESERVED_MASK);
    end
  end

  assign cpi_select = settings_q[sensor_test_config_pkg::CPI_SELECT_BIT];
  assign forced_sleep_select =
    settings_q[sensor_test_config_pkg::FORCED_SLEEP_LSB +: 2];

  // Frame-alive bits: a frame in the clearing cycle still sets them
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_rst_q) begin
      frame_alive_bits_q <= 4'h0;
    end else if (frame_done) begin
      frame_alive_bits_q <= 4'hf;
    end else if (core_wr_ok && wr_addr_q == sensor_test_config_pkg::FRAME_ACTIVITY_STATUS_OFS) begin
      frame_alive_bits_q <= 4'h0;
    end
  end

  // Clear requests for the motion accumulators
  assign clear_dy = clr_fire
    || (rd_fire && !diag_busy_q && rd_addr_q == sensor_test_config_pkg::DELTA_Y_OFS);
  assign clear_dx = clr_fire
    || (rd_fire && !diag_busy_q && rd_addr_q == sensor_test_config_pkg::DELTA_X_OFS);

  // Motion accumulators; a frame arriving with a clear keeps its own delta
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_rst_q) begin
      delta_y_q <= 8'h00;
      delta_x_q <= 8'h00;
    end else begin
      if (clear_dy) begin
        delta_y_q <= frame_done ? frame_info.delta_y : 8'h00;
      end else if (frame_done) begin
        delta_y_q <= sat_add(delta_y_q, frame_info.delta_y);
      end
      if (clear_dx) begin
        delta_x_q <= frame_done ? frame_info.delta_x : 8'h00;
      end else if (frame_done) begin
        delta_x_q <= sat_add(delta_x_q, frame_info.delta_x);
      end
    end
  end

  assign movement_flag = (delta_y_q != 8'h00) || (delta_x_q != 8'h00);

  // Self-test sequencer; done holds until a reset
  always_ff @(posedge core_clk) begin
    if (!reset_n || soft_rst_q) begin
      diag_busy_q <= 1'b0;
      diag_done_q <= 1'b0;
      diag_cnt_q <= 32'h0000_0000;
      diag_result_q <= 32'h0000_0000;
    end else if (diag_busy_q) begin
      if (diag_cnt_q == 32'(DIAG_CYCLES - 1)) begin
        diag_busy_q <= 1'b0;
        diag_done_q <= 1'b1;
        diag_result_q <= diag_pass ? sensor_test_config_pkg::DIAG_PASS_SIGNATURE
                                   : 32'h0000_0000;
      end else begin
        diag_cnt_q <= diag_cnt_q + 32'h0000_0001;
      end
    end else if (core_wr_ok && wr_addr_q == sensor_test_config_pkg::DIAGNOSTIC_START_OFS
                 && wr_data_q[sensor_test_config_pkg::DIAG_RUN_BIT]) begin
      diag_busy_q <= 1'b1;
      diag_cnt_q <= 32'h0000_0000;
    end
  end

  assign diag_running = diag_busy_q;
  assign tracking_enable = !diag_busy_q && !diag_done_q;

  // Register read decode
  always_comb begin
    read_byte = 8'h00;
    unique case (rd_addr_q)
      sensor_test_config_pkg::MOTION_STATUS_OFS: begin
        read_byte[sensor_test_config_pkg::MOVEMENT_FLAG_BIT] = movement_flag;
      end
      sensor_test_config_pkg::DELTA_Y_OFS: read_byte = delta_y_q;
      sensor_test_config_pkg::DELTA_X_OFS: read_byte = delta_x_q;
      sensor_test_config_pkg::SURFACE_QUALITY_OFS: read_byte = frame_info.surface_quality;
      sensor_test_config_pkg::SHUTTER_HIGH_OFS: read_byte = frame_info.shutter[15:8];
      sensor_test_config_pkg::SHUTTER_LOW_OFS: read_byte = frame_info.shutter[7:0];
      sensor_test_config_pkg::PEAK_PIXEL_OFS: read_byte = frame_info.peak_pixel;
      sensor_test_config_pkg::CHECK_RESULT_BYTE_ZERO_OFS: read_byte = diag_result_q[31:24];
      sensor_test_config_pkg::CHECK_RESULT_BYTE_ONE_OFS: read_byte = diag_result_q[23:16];
      sensor_test_config_pkg::CHECK_RESULT_BYTE_TWO_OFS: read_byte = diag_result_q[15:8];
      sensor_test_config_pkg::CHECK_RESULT_BYTE_THREE_OFS: read_byte = diag_result_q[7:0];
      sensor_test_config_pkg::SENSOR_SETTINGS_OFS: read_byte = settings_q;
      sensor_test_config_pkg::FRAME_ACTIVITY_STATUS_OFS: begin
        read_byte = {power_mode, 2'b00, frame_alive_bits_q};
      end
      sensor_test_config_pkg::INVERTED_REVISION_CODE_OFS: begin
        read_byte = ~SILICON_VERSION_CODE;
      end
      sensor_test_config_pkg::INVERTED_PRODUCT_CODE_OFS: read_byte = ~PART_CODE;
      default: read_byte = 8'h00;
    endcase
  end

  // Burst snapshot in transfer order
  always_comb begin
    burst_now.motion_status = 8'h00;
    burst_now.motion_status[sensor_test_config_pkg::MOVEMENT_FLAG_BIT] = movement_flag;
    burst_now.delta_y = delta_y_q;
    burst_now.delta_x = delta_x_q;
    burst_now.surface_quality = frame_info.surface_quality;
    burst_now.shutter_high = frame_info.shutter[15:8];
    burst_now.shutter_low = frame_info.shutter[7:0];
    burst_now.peak_pixel = frame_info.peak_pixel;
  end

  // Answer bundle, loaded once per read address and held for the frame
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bundle_q <= '0;
    end else if (rd_fire && !diag_busy_q) begin
      if (rd_addr_q == sensor_test_config_pkg::MOVEMENT_BURST_PORT_OFS) begin
        bundle_q <= burst_now;
      end else begin
        bundle_q <= {read_byte, 48'h0000_0000_0000};
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/sensor_test_config_pkg.sv ***
// Package: register map, field layout, reset values and timing of the sensor register bank
package sensor_test_config_pkg;

  // Register offsets on the serial port (7-bit address space)
  localparam logic [6:0] MOTION_STATUS_OFS = 7'h02;
  localparam logic [6:0] DELTA_Y_OFS = 7'h03;
  localparam logic [6:0] DELTA_X_OFS = 7'h04;
  localparam logic [6:0] SURFACE_QUALITY_OFS = 7'h05;
  localparam logic [6:0] SHUTTER_HIGH_OFS = 7'h06;
  localparam logic [6:0] SHUTTER_LOW_OFS = 7'h07;
  localparam logic [6:0] PEAK_PIXEL_OFS = 7'h08;
  localparam logic [6:0] CHECK_RESULT_BYTE_ZERO_OFS = 7'h0c;
  localparam logic [6:0] CHECK_RESULT_BYTE_ONE_OFS = 7'h0d;
  localparam logic [6:0] CHECK_RESULT_BYTE_TWO_OFS = 7'h0e;
  localparam logic [6:0] CHECK_RESULT_BYTE_THREE_OFS = 7'h0f;
  localparam logic [6:0] DIAGNOSTIC_START_OFS = 7'h10;
  localparam logic [6:0] SENSOR_SETTINGS_OFS = 7'h11;
  localparam logic [6:0] FRAME_ACTIVITY_STATUS_OFS = 7'h2e;
  localparam logic [6:0] SOFT_RESET_KEY_OFS = 7'h3a;
  localparam logic [6:0] INVERTED_REVISION_CODE_OFS = 7'h3e;
  localparam logic [6:0] INVERTED_PRODUCT_CODE_OFS = 7'h3f;
  localparam logic [6:0] MOVEMENT_BURST_PORT_OFS = 7'h42;

  // Field positions
  localparam int DIAG_RUN_BIT = 0;
  localparam int CPI_SELECT_BIT = 7;
  localparam int FORCED_SLEEP_LSB = 4;
  localparam int MOVEMENT_FLAG_BIT = 7;
  localparam int ADDR_WRITE_BIT = 7;

  // Reset values and fixed codes
  localparam logic [7:0] SENSOR_SETTINGS_RESET = 8'h03;
  localparam logic [7:0] SETTINGS_RESERVED_MASK = 8'h4f;
  localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;
  localparam logic [31:0] DIAG_PASS_SIGNATURE = 32'haf4e_3122;
  localparam logic [2:0] BURST_CLEAR_BYTES = 3'h3;
  localparam int BURST_BYTES = 7;

  // Self-test duration
  localparam int CORE_CLK_KHZ = 50_000;
  localparam int DIAG_RUN_MS = 250;
  localparam int DIAG_RUN_CYCLES = DIAG_RUN_MS * CORE_CLK_KHZ;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP_LEVEL_ONE,
    MODE_SLEEP_LEVEL_TWO,
    MODE_SLEEP_LEVEL_THREE
  } power_mode_type;

  // Per-frame results from the image processor
  typedef struct packed {
    logic [7:0] delta_y;
    logic [7:0] delta_x;
    logic [7:0] surface_quality;
    logic [15:0] shutter;
    logic [7:0] peak_pixel;
  } frame_report_type;

  // Byte order of a burst read, first byte in the top bits
  typedef struct packed {
    logic [7:0] motion_status;
    logic [7:0] delta_y;
    logic [7:0] delta_x;
    logic [7:0] surface_quality;
    logic [7:0] shutter_high;
    logic [7:0] shutter_low;
    logic [7:0] peak_pixel;
  } burst_bundle_type;

endpackage

// *** dv/sensor_test_config_regs_sva.sv ***
// Checker: port-level properties of the sensor register bank
`timescale 1ns/100ps
`default_nettype none

module sensor_test_config_regs_sva #(
  parameter int DIAG_CYCLES = sensor_test_config_pkg::DIAG_RUN_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic diag_running,
  input wire logic tracking_enable,
  input wire logic soft_reset_pulse,
  input wire logic cpi_select,
  input wire logic [1:0] forced_sleep_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  int run_cnt_q;

  // Length of the current self-test run
  always_ff @(posedge core_clk) begin
    if (!reset_n || !diag_running) begin
      run_cnt_q <= 0;
    end else begin
      run_cnt_q <= run_cnt_q + 1;
    end
  end

  a_diag_run_length: assert property ($fell(diag_running) |-> run_cnt_q == DIAG_CYCLES)
    else $error("self-test run length wrong");
  a_diag_holds_on: assert property ($rose(diag_running) |-> diag_running [*8])
    else $error("self-test ended early");
  a_track_off_run: assert property (diag_running && $past(diag_running) |-> !tracking_enable)
    else $error("tracking enabled during self-test");
  a_track_stays_off: assert property (!tracking_enable && !soft_reset_pulse |=> !tracking_enable)
    else $error("tracking resumed without reset");
  a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_soft_defaults: assert property (soft_reset_pulse |=> ##[0:1] (!cpi_select && forced_sleep_select == 2'b00))
    else $error("settings not back to default");
  a_no_reset_in_test: assert property (diag_running |-> !soft_reset_pulse)
    else $error("soft reset during self-test");
  a_miso_quiet: assert property (cs_n |-> !miso_oe)
    else $error("miso driven while deselected");

  c_diag_run: cover property ($fell(diag_running));
  c_soft_reset: cover property (soft_reset_pulse);
  c_read_data: cover property ($rose(miso_oe));
endmodule

bind sensor_test_config_regs sensor_test_config_regs_sva #(
  .DIAG_CYCLES(DIAG_CYCLES)
) i_sensor_test_config_regs_sva (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .cs_n(cs_n),
  .miso_oe(miso_oe),
  .diag_running(diag_running),
  .tracking_enable(tracking_enable),
  .soft_reset_pulse(soft_reset_pulse),
  .cpi_select(cpi_select),
  .forced_sleep_select(forced_sleep_select)
);
`default_nettype wire

// *** dv/serial_master_model.sv ***
// Partner: serial port master, mode 3, MSB first, 30 ns link clock
`timescale 1ns/100ps
`default_nettype none

module serial_master_model (
  output logic link_sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] seen;
  event byte_seen;

  // Idle: clock parked high, deselected
  initial begin
    link_sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // One byte: drive on falling edge, sample on rising edge
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #15 link_sclk = 1'b0;
      mosi = tx[i];
      #15 link_sclk = 1'b1;
      rx[i] = miso;
    end
  endtask

  // One transaction: address byte then n data bytes
  task automatic xact(input logic [7:0] addr, input logic [7:0] wd, input int n,
                      input logic rep);
    logic [7:0] rx;
    #3 cs_n = 1'b0;
    shift(addr, rx);
    if (!addr[7]) begin
      #200; // Address-to-data pause for reads
    end
    for (int k = 0; k < n; k++) begin
      shift(wd, rx);
      if (rep) begin
        seen = rx;
        ->byte_seen;
      end
    end
    #15 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// *** dv/sensor_test_config_regs_bench.sv ***
// Testbench: sensor register bank driven by a serial master model
`timescale 1ns/100ps
`default_nettype none

module sensor_test_config_regs_bench;
  localparam int DIAG_CYCLES = 50;
  localparam logic [7:0] SILICON = 8'h6d; // arbitrary value
  localparam logic [7:0] PART = 8'h92; // arbitrary value
  logic core_clk, reset_n, link_sclk, cs_n, mosi, miso, miso_oe, frame_done, diag_pass;
  logic diag_running, tracking_enable, soft_reset_pulse, cpi_select;
  logic [1:0] forced_sleep_select;
  sensor_test_config_pkg::frame_report_type frame_info, f, g;
  sensor_test_config_pkg::power_mode_type power_mode;
  int miscompares, num_checks, cycles, seed = 37893;
  logic [7:0] exp_q[$], run_len, pulses, d;

  sensor_test_config_regs #(.DIAG_CYCLES(DIAG_CYCLES), .SILICON_VERSION_CODE(SILICON),
    .PART_CODE(PART)) i_sensor_test_config_regs (.core_clk(core_clk), .reset_n(reset_n),
    .link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .frame_done(frame_done), .frame_info(frame_info), .power_mode(power_mode),
    .diag_pass(diag_pass), .diag_running(diag_running), .tracking_enable(tracking_enable),
    .soft_reset_pulse(soft_reset_pulse), .cpi_select(cpi_select),
    .forced_sleep_select(forced_sleep_select));
  serial_master_model i_serial_master_model (.link_sclk(link_sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read n bytes, noting each expected byte first
  task automatic rd(input logic [6:0] a, input logic [55:0] e, input int n);
    for (int k = 0; k < n; k++) exp_q.push_back(e[8*(n-1-k) +: 8]);
    i_serial_master_model.xact({1'b0, a}, 8'h00, n, 1'b1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    i_serial_master_model.xact({1'b1, a}, v, 1, 1'b0);
  endtask

  task automatic frame(input sensor_test_config_pkg::frame_report_type v);
    @(posedge core_clk);
    frame_done <= 1'b1;
    frame_info <= v;
    @(posedge core_clk);
    frame_done <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // Random frame: positive odd Y, small signed X
  task automatic mk;
    f = {$random(seed), 16'($random(seed))};
    f.delta_y = {2'b00, f.delta_y[5:1], 1'b1};
    f.delta_x[7:6] = {2{f.delta_x[5]}};
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Result watcher
  always @(i_serial_master_model.byte_seen) begin
    chk("serial byte", i_serial_master_model.seen, exp_q.pop_front());
  end

  // Timeout, run length and pulse counters
  always @(posedge core_clk) begin
    cycles++;
    if (diag_running === 1'b1) run_len++;
    if (soft_reset_pulse === 1'b1) pulses++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    reset_n = 1'b0;
    frame_done = 1'b0;
    frame_info = '0;
    power_mode = sensor_test_config_pkg::MODE_RUN;
    diag_pass = 1'b1;
    run_len = 8'h00;
    pulses = 8'h00;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(7'h11, 56'h03, 1);
    rd(7'h3e, {48'h0, ~SILICON}, 1);
    rd(7'h3f, {48'h0, ~PART}, 1);
    rd(7'h20, 56'h00, 1);
    // Every sleep level, both resolutions, random reserved bits
    for (int m = 0; m < 4; m++) begin
      d = (8'($random(seed)) & 8'h4f) | {m[0], 1'b0, m[1:0], 4'h0};
      wr(7'h11, d);
      rd(7'h11, {48'h0, (d & 8'hb0) | 8'h03}, 1);
      @(negedge core_clk);
      chk("forced_sleep_select", {6'h0, forced_sleep_select}, 8'(m));
      chk("cpi_select", {7'h0, cpi_select}, {7'h0, d[7]});
    end
    wr(7'h11, 8'h03);
    // Frame-alive set, cleared by a write of any value to 0x2e, mode reported
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      power_mode <= sensor_test_config_pkg::power_mode_type'(m);
      frame('0);
      rd(7'h2e, {48'h0, 2'(m), 6'h0f}, 1);
      wr(7'h2e, 8'($random(seed)));
      rd(7'h2e, {48'h0, 2'(m), 6'h00}, 1);
    end
    // Full burst over two accumulated frames
    mk();
    g = f;
    frame(g);
    mk();
    frame(f);
    rd(7'h42, {8'h80, g.delta_y + f.delta_y, g.delta_x + f.delta_x, f.surface_quality,
               f.shutter, f.peak_pixel}, 7);
    // Minimum burst clears motion
    mk();
    frame(f);
    rd(7'h42, {32'h0, 8'h80, f.delta_y, f.delta_x}, 3);
    rd(7'h02, 56'h00, 1);
    rd(7'h03, 56'h00, 1);
    mk();
    frame(f);
    rd(7'h02, 56'h80, 1);
    rd(7'h03, {48'h0, f.delta_y}, 1);
    rd(7'h03, 56'h00, 1);
    // Keyed soft reset
    wr(7'h11, 8'hb0);
    wr(7'h3a, 8'ha5);
    rd(7'h11, 56'hb3, 1);
    wr(7'h3a, 8'h5a);
    rd(7'h11, 56'h03, 1);
    wr(7'h10, 8'hfe);
    @(negedge core_clk);
    chk("diag_running", {7'h0, diag_running}, 8'h00);
    // Passing then failing self-test, each followed by a reset
    for (int p = 1; p >= 0; p--) begin
      @(posedge core_clk);
      diag_pass <= p[0];
      wr(7'h10, 8'h01);
      for (int w = 0; w < 200 && diag_running !== 1'b0; w++) @(negedge core_clk);
      chk("tracking_enable", {7'h0, tracking_enable}, 8'h00);
      for (int k = 0; k < 4; k++) begin
        d = p[0] ? sensor_test_config_pkg::DIAG_PASS_SIGNATURE[31-8*k -: 8] : 8'h00;
        rd(7'h0c + 7'(k), {48'h0, d}, 1);
      end
      wr(7'h3a, 8'h5a);
      @(negedge core_clk);
      chk("tracking_enable", {7'h0, tracking_enable}, 8'h01);
    end
    chk("diag cycles", run_len, 8'(2 * DIAG_CYCLES));
    chk("soft resets", pulses, 8'h03);
    report_and_stop();
  end
endmodule
`default_nettype wire
